// ==== mbf_consts.svh ====
// register offsets, field positions, reset values and timing for the bias fault block
`ifndef MBF_CONSTS_SVH
`define MBF_CONSTS_SVH

`define MBF_ADDR_AUX_HIGH        8'h4E
`define MBF_ADDR_AUX_LOW         8'h4F
`define MBF_ADDR_PD_CTRL         8'h50
`define MBF_ADDR_BIAS_OV_MARGIN  8'h51
`define MBF_ADDR_INPUT_MARGINS   8'h52

`define MBF_RST_AUX_HIGH         8'hBA
`define MBF_RST_AUX_LOW          8'h4B
`define MBF_RST_PD_CTRL          8'h88
`define MBF_RST_BIAS_OV_MARGIN   8'h40
`define MBF_RST_INPUT_MARGINS    8'h44
`define MBF_RST_BIAS_OV_CODE     3'h2
`define MBF_RST_IN_SHORT_CODE    3'h2
`define MBF_RST_IN_OV_CODE       3'h1
`define MBF_RST_BIAS_OV_MV       9'h03C
`define MBF_RST_IN_SHORT_MV      9'h03C
`define MBF_RST_IN_OV_MV         9'h01E

`define MBF_BIT_OFF_SHORT        7
`define MBF_BIT_OFF_HIGH_CUR     6
`define MBF_BIT_OFF_LOW_CUR      5
`define MBF_BIT_OFF_OVERVOLT     4
`define MBF_BIT_OFF_OVERTEMP     3
`define MBF_BIT_MAN_RECOVERY     2
`define MBF_BIT_AUTO_RECOVERY    1
`define MBF_BIT_SHORT_DET_DIS    0

`define MBF_MARGIN_HI            7
`define MBF_MARGIN_LO            5
`define MBF_IN_OV_HI             4
`define MBF_IN_OV_LO             2

// margin step in millivolts, one code step
`define MBF_MARGIN_STEP_MV       8'd30

`define MBF_DBNC_SEL_16          2'h0
`define MBF_DBNC_SEL_8           2'h1
`define MBF_DBNC_SEL_4           2'h2
`define MBF_DBNC_SEL_NONE        2'h3
`define MBF_DBNC_CNT_16          5'd16
`define MBF_DBNC_CNT_8           5'd8
`define MBF_DBNC_CNT_4           5'd4

`endif

// ==== mbf_pkg.sv ====
// types shared by the bias fault configuration block
package mbf_pkg;

    typedef struct packed {
        logic short_ckt;
        logic high_current;
        logic low_current;
        logic overvoltage;
        logic overtemp;
    } mbf_faults_t;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mbf_reg_req_t;

    typedef enum logic [2:0] {
        MBF_BIAS_ON  = 3'b001,
        MBF_BIAS_OFF = 3'b010,
        MBF_RECHECK  = 3'b100
    } mbf_bias_state_t;

endpackage

// ==== mbf_debounce.sv ====
// one fault debounce filter with selectable count
`timescale 1ns/1ps
`include "mbf_consts.svh"

module mbf_debounce
    import mbf_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    input  wire logic [1:0] sel_in,
    input  wire logic       raw_in,
    output logic            fault_out
);

    logic [4:0] count;
    logic [4:0] next_count;
    logic       next_fault;
    logic [4:0] target;

    always_comb
    begin
        unique case (sel_in)
            `MBF_DBNC_SEL_16: target = `MBF_DBNC_CNT_16;
            `MBF_DBNC_SEL_8:  target = `MBF_DBNC_CNT_8;
            `MBF_DBNC_SEL_4:  target = `MBF_DBNC_CNT_4;
            default:          target = 5'h00;
        endcase
        next_count = count;
        next_fault = fault_out;
        // any change of the raw level restarts the count so glitches shorter than a nonzero target never report
        if (raw_in == fault_out)
        begin
            next_count = 5'h00;
        end
        else if (target == 5'h00 || count + 5'h01 >= target)
        begin
            next_fault = raw_in;
            next_count = 5'h00;
        end
        else
        begin
            next_count = count + 5'h01;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            count     <= 5'h00;
            fault_out <= 1'b0;
        end
        else if (ce_in)
        begin
            count     <= next_count;
            fault_out <= next_fault;
        end
    end

endmodule

// ==== mbf_bias_fault_cfg.sv ====
// diagnostic limit, bias fault power-down and safe-band configuration registers
// ==========================================================================
// Notes on behaviour
// - eight-bit aux monitor high limit code, volts = ((0.9*code*16/4095)-0.225)*6
// - eight-bit aux monitor low limit code, same scale, resets to 0x4B
// - short-circuit power-down switch, reset 1, short fault turns bias off
// - high-current power-down switch, reset 0, high-current fault turns bias off
// - low-current power-down switch, reset 0, low-current fault turns bias off
// - over-voltage power-down switch, reset 0, over-voltage fault turns bias off
// - over-temperature power-down switch, reset 1, over-temp fault turns bias off
// - writing one to manual recovery rechecks faults, self clears; zero ignored
// - auto-recovery enable restores bias automatically once faults are gone
// - short detector runs while disable bit is zero, off when one
// - bias over-voltage lower margin, bits 7..5, code times 30 mV
// - input short-to-bias upper margin, bits 7..5, reset 010, code times 30 mV
// - input over-voltage lower margin, bits 4..2, reset 001, code times 30 mV
// - threshold doubling bit doubles the aux high and low limit thresholds, not the margins
// - fault detections debounced by 16, 8, 4 counts or not at all
`timescale 1ns/1ps
`include "mbf_consts.svh"

module mbf_bias_fault_cfg
    import mbf_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic         ce_in,
    input  wire mbf_reg_req_t reg_req_in,
    input  wire mbf_faults_t  fault_raw_in,
    input  wire logic [1:0]   fault_debounce_select_in,
    input  wire logic         threshold_double_scale_in,
    output logic [7:0]        reg_rdata_out,
    output logic              bias_enable_out,
    output logic              bias_short_detect_en_out,
    output mbf_faults_t       fault_status_out,
    output logic [7:0]        aux_high_limit_code_out,
    output logic [7:0]        aux_low_limit_code_out,
    output logic [8:0]        aux_high_limit_eff_out,
    output logic [8:0]        aux_low_limit_eff_out,
    output logic [8:0]        bias_overvoltage_margin_mv_out,
    output logic [8:0]        input_to_bias_short_margin_mv_out,
    output logic [8:0]        input_overvoltage_margin_mv_out
);

    // ======================================================================
    // fault input synchronisers and debounce
    logic [4:0]  fault_meta;
    logic [4:0]  fault_sync;
    logic [4:0]  fault_deb;
    mbf_faults_t faults;

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            fault_meta <= 5'h00;
            fault_sync <= 5'h00;
        end
        else if (ce_in)
        begin
            fault_meta <= fault_raw_in;
            fault_sync <= fault_meta;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_deb
            mbf_debounce u_deb (
                .clk_in    (clk_in),
                .resetn_in (resetn_in),
                .ce_in     (ce_in),
                .sel_in    (fault_debounce_select_in),
                .raw_in    (fault_sync[gi]),
                .fault_out (fault_deb[gi])
            );
        end
    endgenerate

    // ======================================================================
    // register file
    logic [7:0] aux_high;
    logic [7:0] aux_low;
    logic [7:0] pd_ctrl;
    logic [2:0] bias_ov_margin;
    logic [2:0] in_short_margin;
    logic [2:0] in_ov_margin;
    logic [7:0] next_aux_high;
    logic [7:0] next_aux_low;
    logic [7:0] next_pd_ctrl;
    logic [2:0] next_bias_ov_margin;
    logic [2:0] next_in_short_margin;
    logic [2:0] next_in_ov_margin;
    logic [7:0] next_rdata;
    logic       recheck_start;

    always_comb
    begin
        next_aux_high        = aux_high;
        next_aux_low         = aux_low;
        next_pd_ctrl         = pd_ctrl;
        next_bias_ov_margin  = bias_ov_margin;
        next_in_short_margin = in_short_margin;
        next_in_ov_margin    = in_ov_margin;
        // recovery trigger is a one-shot; it never holds between writes
        next_pd_ctrl[`MBF_BIT_MAN_RECOVERY] = 1'b0;
        if (reg_req_in.wr_en)
        begin
            unique case (reg_req_in.addr)
                `MBF_ADDR_AUX_HIGH: next_aux_high = reg_req_in.wdata;
                `MBF_ADDR_AUX_LOW:  next_aux_low  = reg_req_in.wdata;
                `MBF_ADDR_PD_CTRL:  next_pd_ctrl  = reg_req_in.wdata;
                `MBF_ADDR_BIAS_OV_MARGIN:
                    next_bias_ov_margin =
                        reg_req_in.wdata[`MBF_MARGIN_HI:`MBF_MARGIN_LO];
                `MBF_ADDR_INPUT_MARGINS:
                begin
                    next_in_short_margin =
                        reg_req_in.wdata[`MBF_MARGIN_HI:`MBF_MARGIN_LO];
                    next_in_ov_margin =
                        reg_req_in.wdata[`MBF_IN_OV_HI:`MBF_IN_OV_LO];
                end
                default: ;
            endcase
        end
        // reserved positions stay zero whatever software writes
        next_rdata = 8'h00;
        if (reg_req_in.rd_en)
        begin
            unique case (reg_req_in.addr)
                `MBF_ADDR_AUX_HIGH:       next_rdata = aux_high;
                `MBF_ADDR_AUX_LOW:        next_rdata = aux_low;
                `MBF_ADDR_PD_CTRL:        next_rdata = pd_ctrl;
                `MBF_ADDR_BIAS_OV_MARGIN: next_rdata = {bias_ov_margin, 5'h00};
                `MBF_ADDR_INPUT_MARGINS:  next_rdata = {in_short_margin, in_ov_margin, 2'h0};
                default:                  next_rdata = 8'h00;
            endcase
        end
    end

    assign recheck_start = pd_ctrl[`MBF_BIT_MAN_RECOVERY];

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            aux_high        <= `MBF_RST_AUX_HIGH;
            aux_low         <= `MBF_RST_AUX_LOW;
            pd_ctrl         <= `MBF_RST_PD_CTRL;
            bias_ov_margin  <= `MBF_RST_BIAS_OV_CODE;
            in_short_margin <= `MBF_RST_IN_SHORT_CODE;
            in_ov_margin    <= `MBF_RST_IN_OV_CODE;
            reg_rdata_out   <= 8'h00;
        end
        else if (ce_in)
        begin
            aux_high        <= next_aux_high;
            aux_low         <= next_aux_low;
            pd_ctrl         <= next_pd_ctrl;
            bias_ov_margin  <= next_bias_ov_margin;
            in_short_margin <= next_in_short_margin;
            in_ov_margin    <= next_in_ov_margin;
            reg_rdata_out   <= next_rdata;
        end
    end

    // ======================================================================
    // fault gating and bias power state
    logic            trip;
    logic            any_fault;
    mbf_bias_state_t state;
    mbf_bias_state_t next_state;
    logic            next_bias_en;

    always_comb
    begin
        faults = fault_deb;
        // a disabled short detector can never report
        if (pd_ctrl[`MBF_BIT_SHORT_DET_DIS])
        begin
            faults.short_ckt = 1'b0;
        end
    end

    always_comb
    begin
        trip = (pd_ctrl[`MBF_BIT_OFF_SHORT]    & faults.short_ckt)
             | (pd_ctrl[`MBF_BIT_OFF_HIGH_CUR] & faults.high_current)
             | (pd_ctrl[`MBF_BIT_OFF_LOW_CUR]  & faults.low_current)
             | (pd_ctrl[`MBF_BIT_OFF_OVERVOLT] & faults.overvoltage)
             | (pd_ctrl[`MBF_BIT_OFF_OVERTEMP] & faults.overtemp);
        any_fault = trip;
        next_state   = state;
        unique case (state)
            MBF_BIAS_ON:
                if (trip)
                begin
                    next_state = MBF_BIAS_OFF;
                end
            MBF_BIAS_OFF:
                // stays off until a recovery path is asked for
                if (recheck_start || pd_ctrl[`MBF_BIT_AUTO_RECOVERY])
                begin
                    next_state = MBF_RECHECK;
                end
            MBF_RECHECK:
                next_state = any_fault ? MBF_BIAS_OFF : MBF_BIAS_ON;
            default:
                next_state = MBF_BIAS_OFF;
        endcase
        next_bias_en = (next_state == MBF_BIAS_ON);
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            state           <= MBF_BIAS_ON;
            bias_enable_out <= 1'b1;
        end
        else if (ce_in)
        begin
            state           <= next_state;
            bias_enable_out <= next_bias_en;
        end
    end

    // ======================================================================
    // effective thresholds and margins for the measurement engine
    logic [8:0] next_hi_eff;
    logic [8:0] next_lo_eff;
    logic [8:0] next_m_bias;
    logic [8:0] next_m_short;
    logic [8:0] next_m_inov;

    always_comb
    begin
        next_hi_eff  = threshold_double_scale_in ? {aux_high, 1'b0} : {1'b0, aux_high};
        next_lo_eff  = threshold_double_scale_in ? {aux_low, 1'b0} : {1'b0, aux_low};
        next_m_bias  = 9'(bias_ov_margin * `MBF_MARGIN_STEP_MV);
        next_m_short = 9'(in_short_margin * `MBF_MARGIN_STEP_MV);
        next_m_inov  = 9'(in_ov_margin * `MBF_MARGIN_STEP_MV);
    end

    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            aux_high_limit_code_out           <= `MBF_RST_AUX_HIGH;
            aux_low_limit_code_out            <= `MBF_RST_AUX_LOW;
            aux_high_limit_eff_out            <= {1'b0, `MBF_RST_AUX_HIGH};
            aux_low_limit_eff_out             <= {1'b0, `MBF_RST_AUX_LOW};
            bias_overvoltage_margin_mv_out    <= `MBF_RST_BIAS_OV_MV;
            input_to_bias_short_margin_mv_out <= `MBF_RST_IN_SHORT_MV;
            input_overvoltage_margin_mv_out   <= `MBF_RST_IN_OV_MV;
            bias_short_detect_en_out          <= 1'b1;
            fault_status_out                  <= 5'h00;
        end
        else if (ce_in)
        begin
            aux_high_limit_code_out           <= aux_high;
            aux_low_limit_code_out            <= aux_low;
            aux_high_limit_eff_out            <= next_hi_eff;
            aux_low_limit_eff_out             <= next_lo_eff;
            bias_overvoltage_margin_mv_out    <= next_m_bias;
            input_to_bias_short_margin_mv_out <= next_m_short;
            input_overvoltage_margin_mv_out   <= next_m_inov;
            bias_short_detect_en_out          <= ~pd_ctrl[`MBF_BIT_SHORT_DET_DIS];
            fault_status_out                  <= faults;
        end
    end

    // ======================================================================
    // checks
    sequence s_tripped;
        state == MBF_BIAS_ON && trip && ce_in;
    endsequence

    property p_trip_off;
        @(posedge clk_in) disable iff (!resetn_in)
        s_tripped |=> !bias_enable_out;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("bias stayed on after fault");

    property p_ot_default;
        @(posedge clk_in) disable iff (!resetn_in)
        (ce_in && state == MBF_BIAS_ON && faults.overtemp && pd_ctrl[`MBF_BIT_OFF_OVERTEMP])
            |=> state == MBF_BIAS_OFF;
    endproperty
    a_ot_default: assert property (p_ot_default) else $error("overtemp did not trip");

    property p_no_trip_masked;
        @(posedge clk_in) disable iff (!resetn_in)
        (ce_in && state == MBF_BIAS_ON && !trip) |=> state == MBF_BIAS_ON;
    endproperty
    a_no_trip_masked: assert property (p_no_trip_masked) else $error("bias dropped");

    property p_self_clear;
        @(posedge clk_in) disable iff (!resetn_in)
        (ce_in && recheck_start && !(reg_req_in.wr_en && reg_req_in.addr == `MBF_ADDR_PD_CTRL))
            |=> !pd_ctrl[`MBF_BIT_MAN_RECOVERY];
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("recovery bit stuck");

    property p_stays_off;
        @(posedge clk_in) disable iff (!resetn_in)
        (ce_in && state == MBF_BIAS_OFF && !recheck_start && !pd_ctrl[`MBF_BIT_AUTO_RECOVERY])
            |=> state == MBF_BIAS_OFF;
    endproperty
    a_stays_off: assert property (p_stays_off) else $error("bias left off state alone");

    property p_recover;
        @(posedge clk_in) disable iff (!resetn_in)
        (ce_in && state == MBF_BIAS_OFF && pd_ctrl[`MBF_BIT_AUTO_RECOVERY])
            |=> state == MBF_RECHECK;
    endproperty
    a_recover: assert property (p_recover) else $error("auto recovery not started");

    property p_short_dis;
        @(posedge clk_in) disable iff (!resetn_in)
        (ce_in && pd_ctrl[`MBF_BIT_SHORT_DET_DIS]) |=> !fault_status_out.short_ckt;
    endproperty
    a_short_dis: assert property (p_short_dis) else $error("short seen while disabled");

    property p_margin;
        @(posedge clk_in) disable iff (!resetn_in)
        ce_in |=> input_overvoltage_margin_mv_out == 9'($past(in_ov_margin)) * 9'd30;
    endproperty
    a_margin: assert property (p_margin) else $error("margin scale wrong");

    property p_double;
        @(posedge clk_in) disable iff (!resetn_in)
        (ce_in && threshold_double_scale_in) |=> aux_high_limit_eff_out == {$past(aux_high), 1'b0};
    endproperty
    a_double: assert property (p_double) else $error("threshold not doubled");

endmodule

// ==== tb.sv ====
// self-checking testbench for the bias fault configuration registers
`timescale 1ns/1ps
`include "mbf_consts.svh"

module tb
    import mbf_pkg::*;
;
    logic         clk_in;
    logic         resetn_in;
    logic         ce_in;
    mbf_reg_req_t reg_req_in;
    mbf_faults_t  fault_raw_in;
    logic [1:0]   sel;
    logic         dbl;
    logic [7:0]   rdata;
    logic         bias_on;
    logic         det_en;
    mbf_faults_t  status;
    logic [7:0]   hi_code;
    logic [7:0]   lo_code;
    logic [8:0]   hi_eff;
    logic [8:0]   lo_eff;
    logic [8:0]   mv_bov;
    logic [8:0]   mv_ish;
    logic [8:0]   mv_iov;
    int           n_errors;
    int           comparisons;
    logic [7:0]   hi;
    logic [7:0]   lo;
    logic [2:0]   m1;
    logic [2:0]   m2;
    logic [2:0]   m3;
    logic [7:0]   mask;

    mbf_bias_fault_cfg dut (
        .clk_in                            (clk_in),
        .resetn_in                         (resetn_in),
        .ce_in                             (ce_in),
        .reg_req_in                        (reg_req_in),
        .fault_raw_in                      (fault_raw_in),
        .fault_debounce_select_in          (sel),
        .threshold_double_scale_in         (dbl),
        .reg_rdata_out                     (rdata),
        .bias_enable_out                   (bias_on),
        .bias_short_detect_en_out          (det_en),
        .fault_status_out                  (status),
        .aux_high_limit_code_out           (hi_code),
        .aux_low_limit_code_out            (lo_code),
        .aux_high_limit_eff_out            (hi_eff),
        .aux_low_limit_eff_out             (lo_eff),
        .bias_overvoltage_margin_mv_out    (mv_bov),
        .input_to_bias_short_margin_mv_out (mv_ish),
        .input_overvoltage_margin_mv_out   (mv_iov)
    );

    // ==========================================================================
    // expectations
    function automatic logic [8:0] exp_eff(input logic [7:0] c, input logic d);
        return d ? {c, 1'b0} : {1'b0, c};
    endfunction

    function automatic logic [8:0] exp_mv(input logic [2:0] c);
        return 9'(c) * 9'h01E;
    endfunction

    // ==========================================================================
    // bus and check tasks
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // request held over one taken edge, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req_in = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        step(1);
        reg_req_in = '0;
        step(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_req_in = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        step(1);
        chk(what, {1'b0, exp}, {1'b0, rdata});
        reg_req_in = '0;
        step(1);
    endtask

    task automatic wait_bias(input logic exp, input int bound);
        int k;
        k = 0;
        while (bias_on !== exp && k < bound)
        begin
            step(1);
            k++;
        end
        chk("bias_enable", {8'h00, exp}, {8'h00, bias_on});
        if (bias_on !== exp)
            end_of_test();
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // ==========================================================================
    // main sequence
    initial
    begin
        resetn_in = 1'b0;
        ce_in = 1'b1;
        reg_req_in = '0;
        fault_raw_in = '0;
        sel = 2'h3;
        dbl = 1'b0;
        n_errors = 0;
        comparisons = 0;
        void'($urandom(32'h0F7F4DF4));
        repeat (8) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        step(1);
        chk("bias_on_rst", 9'h001, {8'h00, bias_on});
        chk("det_en_rst", 9'h001, {8'h00, det_en});
        chk("mv_bov_rst", exp_mv(3'h2), mv_bov);
        chk("mv_ish_rst", exp_mv(3'h2), mv_ish);
        chk("mv_iov_rst", exp_mv(3'h1), mv_iov);
        rd(`MBF_ADDR_AUX_HIGH, `MBF_RST_AUX_HIGH, "rst_aux_high");
        rd(`MBF_ADDR_AUX_LOW, 8'h4B, "rst_aux_low");
        rd(`MBF_ADDR_PD_CTRL, 8'h88, "rst_pd_ctrl");
        rd(`MBF_ADDR_BIAS_OV_MARGIN, 8'h40, "rst_bov");
        rd(`MBF_ADDR_INPUT_MARGINS, 8'h44, "rst_inm");
        rd(8'h53, 8'h00, "unmapped");
        $display("test reset done");

        // limits and margins, corners first then random
        for (int i = 0; i < 20; i++)
        begin
            hi = (i == 0) ? 8'hFF : 8'($urandom);
            lo = (i == 0) ? 8'h00 : 8'($urandom);
            m1 = (i == 0) ? 3'h7 : 3'($urandom);
            m2 = (i == 0) ? 3'h0 : 3'($urandom);
            m3 = (i == 0) ? 3'h7 : 3'($urandom);
            dbl = (i == 0) ? 1'b1 : 1'($urandom);
            wr(`MBF_ADDR_AUX_HIGH, hi);
            wr(`MBF_ADDR_AUX_LOW, lo);
            wr(`MBF_ADDR_BIAS_OV_MARGIN, {m1, 5'h00});
            wr(`MBF_ADDR_INPUT_MARGINS, {m2, m3, 2'h0});
            rd(`MBF_ADDR_AUX_HIGH, hi, "aux_high");
            rd(`MBF_ADDR_AUX_LOW, lo, "aux_low");
            rd(`MBF_ADDR_BIAS_OV_MARGIN, {m1, 5'h00}, "bov");
            rd(`MBF_ADDR_INPUT_MARGINS, {m2, m3, 2'h0}, "inm");
            chk("hi_code", {1'b0, hi}, {1'b0, hi_code});
            chk("lo_code", {1'b0, lo}, {1'b0, lo_code});
            chk("hi_eff", exp_eff(hi, dbl), hi_eff);
            chk("lo_eff", exp_eff(lo, dbl), lo_eff);
            chk("mv_bov", exp_mv(m1), mv_bov);
            chk("mv_ish", exp_mv(m2), mv_ish);
            chk("mv_iov", exp_mv(m3), mv_iov);
        end
        // a write while the clock enable is low must not land
        ce_in = 1'b0;
        wr(`MBF_ADDR_AUX_HIGH, ~hi);
        ce_in = 1'b1;
        rd(`MBF_ADDR_AUX_HIGH, hi, "aux_high_ce");
        $display("test config done");

        // each power-down switch alone, manual recovery refused while faulty
        for (int i = 0; i < 5; i++)
        begin
            mask = 8'h80 >> i;
            sel = (i < 3) ? 2'(i) : 2'($urandom);
            wr(`MBF_ADDR_PD_CTRL, mask);
            fault_raw_in = mbf_faults_t'(5'h10 >> i);
            wait_bias(1'b0, 40);
            chk("status", {4'h0, 5'h10 >> i}, {4'h0, status});
            wr(`MBF_ADDR_PD_CTRL, mask | 8'h04);
            step(8);
            chk("bias_faulty", 9'h000, {8'h00, bias_on});
            fault_raw_in = '0;
            step(30);
            chk("bias_held", 9'h000, {8'h00, bias_on});
            wr(`MBF_ADDR_PD_CTRL, mask | 8'h04);
            wait_bias(1'b1, 10);
            rd(`MBF_ADDR_PD_CTRL, mask, "pd_self_clear");
        end
        $display("test switches done");

        // switches cleared: faults reported but bias kept
        sel = 2'h3;
        wr(`MBF_ADDR_PD_CTRL, 8'h00);
        fault_raw_in = mbf_faults_t'(5'h1F);
        step(30);
        chk("bias_no_pd", 9'h001, {8'h00, bias_on});
        chk("status_all", 9'h01F, {4'h0, status});
        fault_raw_in = '0;
        step(30);
        // short detector disabled
        wr(`MBF_ADDR_PD_CTRL, 8'h81);
        chk("det_off", 9'h000, {8'h00, det_en});
        fault_raw_in = mbf_faults_t'(5'h10);
        step(30);
        chk("bias_det_off", 9'h001, {8'h00, bias_on});
        chk("status_det_off", 9'h000, {4'h0, status});
        fault_raw_in = '0;
        wr(`MBF_ADDR_PD_CTRL, 8'h80);
        chk("det_on", 9'h001, {8'h00, det_en});
        $display("test detect done");

        // automatic recovery
        wr(`MBF_ADDR_PD_CTRL, 8'h42);
        fault_raw_in = mbf_faults_t'(5'h08);
        wait_bias(1'b0, 40);
        fault_raw_in = '0;
        wait_bias(1'b1, 60);
        $display("test auto done");

        // a pulse shorter than sixteen counts is filtered, unfiltered it trips
        sel = 2'h0;
        wr(`MBF_ADDR_PD_CTRL, 8'h08);
        fault_raw_in = mbf_faults_t'(5'h01);
        step(6);
        fault_raw_in = '0;
        step(30);
        chk("bias_filtered", 9'h001, {8'h00, bias_on});
        sel = 2'h3;
        fault_raw_in = mbf_faults_t'(5'h01);
        wait_bias(1'b0, 10);
        fault_raw_in = '0;
        step(10);
        wr(`MBF_ADDR_PD_CTRL, 8'h0C);
        wait_bias(1'b1, 10);
        $display("test debounce done");
        end_of_test();
    end
endmodule
